// ---- inc/nopb_defs.vh ----
// constants of the neutral overvoltage pickup block
`ifndef NOPB_DEFS_VH
`define NOPB_DEFS_VH

// register byte offsets
`define NOPB_REG_THRESH   5'h00
`define NOPB_REG_CONFIG   5'h04
`define NOPB_REG_STATUS   5'h08
`define NOPB_REG_RATIO    5'h0c
`define NOPB_REG_TIMES    5'h10
`define NOPB_REG_BLKINFO  5'h14
`define NOPB_REG_STAMP    5'h18
`define NOPB_REG_COUNT    5'h1c

// threshold in 0.01 % of nominal voltage
`define NOPB_THR_W        14
`define NOPB_THR_DEFAULT  14'h07d0
`define NOPB_THR_MIN      14'h0064
`define NOPB_THR_MAX      14'h26ac

// release below 97 % of threshold
`define NOPB_RESET_PCT    7'h61
`define NOPB_FULL_PCT     7'h64

// config fields
`define NOPB_CFG_MODE_LSB 0
`define NOPB_CFG_FEN_BIT  3
`define NOPB_CFG_FBLK_BIT 4
`define NOPB_CFG_SEL_LSB  5
`define NOPB_CFG_INST_BIT 7
`define NOPB_CFG_DEFAULT  8'h01

// operating mode codes
`define NOPB_MODE_ON      3'h1
`define NOPB_MODE_BLOCKED 3'h2
`define NOPB_MODE_TEST    3'h3
`define NOPB_MODE_TESTBLK 3'h4
`define NOPB_MODE_OFF     3'h5

// input selection and measuring-now codes
`define NOPB_SEL_AUTO     2'h0
`define NOPB_SEL_CALC     2'h1
`define NOPB_SEL_CH3      2'h2
`define NOPB_SEL_CH4      2'h3
`define NOPB_SRC_NONE     2'h0
`define NOPB_SRC_CALC     2'h1
`define NOPB_SRC_CH3      2'h2
`define NOPB_SRC_CH4      2'h3

// ratio saturates at 250.00
`define NOPB_RATIO_MAX    16'h61a8
// phase counted as faulted below 50 % nominal
`define NOPB_PHASE_LOW    16'h1388

// time stamp tick: 1 ms at 125 MHz
`define NOPB_CLK_MHZ      125
`define NOPB_STAMP_US     1000
`define NOPB_STAMP_CYCLES (`NOPB_STAMP_US * `NOPB_CLK_MHZ)

`endif

// ---- verilog/nopb_pickup.v ----
// pickup, blocking and status logic of one neutral overvoltage stage
// How it works
// [RQ1] pickup sets when measured neutral voltage exceeds the threshold
// [RQ2] pickup clears only below 97 percent of the threshold or in mode off
// [RQ3] threshold in 0.01 percent nominal steps, default 20 percent
// [RQ4] start only while pickup is set and blocking is inactive
// [RQ5] blocking sampled once at each processing cycle start
// [RQ6] blocking comes from a dedicated input fed by the block matrix
// [RQ7] unblocked pickup raises start for the operating-time logic
// [RQ8] blocked pickup raises blocked and never starts the timers
// [RQ9] blocking during start drops start and triggers release handling
// [RQ10] blocking gives a display pulse and stamped event with voltage, fault
// [RQ11] the outside must present blocking 5 ms before the delay expires
// [RQ12] with forcing enabled a software switch drives blocking
// [RQ13] measuring-now code: 0 none, 1 calculated, 2 third, 3 fourth
// [RQ14] auto selection: calculated if phase-neutral inputs, else third, else fourth residual channel, else none
// [RQ15] ratio of measured voltage to threshold computed every cycle
// [RQ16] ratio exposed in hundredths
// [RQ17] remaining time to trip exposed in 5 ms units while counting
// [RQ18] expected operating time exposed, refreshed as measurement changes
// [RQ19] effective mode reported: 1 on, 2 blocked, 3 test, 4 test/blk, 5 off
// [RQ20] instant mode raises start and trip together with one stamp
// [RQ21] zero-sequence is one third of the three phase voltages
// [RQ22] pickup, start and blocked change only at cycle boundaries
`include "nopb_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module nopb_pickup #(
    parameter STAMP_CYCLES = `NOPB_STAMP_CYCLES
) (
    input  wire        clk,
    input  wire        reset,
    input  wire [4:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    input  wire        cycle_start,
    input  wire [15:0] phase1_voltage,
    input  wire [15:0] phase2_voltage,
    input  wire [15:0] phase3_voltage,
    input  wire [15:0] third_voltage_channel,
    input  wire [15:0] fourth_voltage_channel,
    input  wire        phase_neutral_present,
    input  wire        third_is_residual,
    input  wire        fourth_is_residual,
    input  wire        block_matrix_in,
    input  wire        timer_counting,
    input  wire [15:0] timer_remaining,
    input  wire [15:0] timer_expected,
    output reg         pickup,
    output reg         start,
    output reg         blocked,
    output reg         trip,
    output reg         release_start,
    output reg         block_event,
    output reg         display_event,
    output reg  [31:0] event_stamp,
    output reg  [15:0] event_voltage,
    output reg  [2:0]  event_fault_type
);

    // effective mode: invalid codes fall back to on
    function [2:0] nopb_eff_mode;
        input [2:0] m;
        begin
            if (m >= `NOPB_MODE_ON && m <= `NOPB_MODE_OFF)
                nopb_eff_mode = m;
            else
                nopb_eff_mode = `NOPB_MODE_ON;
        end
    endfunction

    // clamp a written threshold into its legal range
    function [`NOPB_THR_W-1:0] nopb_clamp_thr;
        input [31:0] v;
        begin
            if (v < {18'h0, `NOPB_THR_MIN})
                nopb_clamp_thr = `NOPB_THR_MIN;
            else if (v > {18'h0, `NOPB_THR_MAX})
                nopb_clamp_thr = `NOPB_THR_MAX;
            else
                nopb_clamp_thr = v[`NOPB_THR_W-1:0];
        end
    endfunction

    reg [`NOPB_THR_W-1:0] threshold;
    reg [7:0]             config_reg;
    reg [1:0]             source;
    reg [15:0]            ratio;
    reg [15:0]            remaining;
    reg [15:0]            expected;
    reg                   counting;
    reg                   block_sampled;
    reg [15:0]            block_count;
    reg [31:0]            ms_count;
    reg [31:0]            tick_count;
    reg [15:0]            um;
    reg [1:0]             next_source;
    reg [31:0]            next_readdata;
    wire [2:0]            mode;
    wire [17:0]           phase_sum;
    wire [15:0]           calc_voltage;
    wire [22:0]           um_scaled;
    wire [22:0]           thr_scaled;
    wire [22:0]           ratio_full;
    wire                  soft_block;
    wire                  mode_block;
    wire                  mode_off;
    wire                  above;
    wire                  below_reset;
    wire                  next_pickup;
    wire                  next_start;
    wire                  next_blocked;
    wire                  instant;
    wire [2:0]            fault_type;

    assign mode = nopb_eff_mode(config_reg[`NOPB_CFG_MODE_LSB +: 3]);
    assign instant = config_reg[`NOPB_CFG_INST_BIT];
    assign mode_off = (mode == `NOPB_MODE_OFF);
    assign mode_block = (mode == `NOPB_MODE_BLOCKED) || (mode == `NOPB_MODE_TESTBLK);

    // [RQ12] forced blocking switch
    assign soft_block = config_reg[`NOPB_CFG_FEN_BIT] & config_reg[`NOPB_CFG_FBLK_BIT];

    // [RQ21] one third of phase sum
    assign phase_sum = {2'h0, phase1_voltage} + {2'h0, phase2_voltage}
                     + {2'h0, phase3_voltage};
    assign calc_voltage = 16'(phase_sum / 18'd3);

    // [RQ13] [RQ14] source selection; a channel not in residual mode is unusable
    always @* begin
        next_source = `NOPB_SRC_NONE;
        case (config_reg[`NOPB_CFG_SEL_LSB +: 2])
            `NOPB_SEL_CALC: begin
                if (phase_neutral_present)
                    next_source = `NOPB_SRC_CALC;
            end
            `NOPB_SEL_CH3: begin
                if (third_is_residual)
                    next_source = `NOPB_SRC_CH3;
            end
            `NOPB_SEL_CH4: begin
                if (fourth_is_residual)
                    next_source = `NOPB_SRC_CH4;
            end
            default: begin
                if (phase_neutral_present)
                    next_source = `NOPB_SRC_CALC;
                else if (third_is_residual)
                    next_source = `NOPB_SRC_CH3;
                else if (fourth_is_residual)
                    next_source = `NOPB_SRC_CH4;
            end
        endcase
    end

    // selected measurement; no source reads as zero so nothing picks up
    always @* begin
        case (next_source)
            `NOPB_SRC_CALC: um = calc_voltage;
            `NOPB_SRC_CH3:  um = third_voltage_channel;
            `NOPB_SRC_CH4:  um = fourth_voltage_channel;
            default:        um = 16'h0000;
        endcase
    end

    // [RQ1] [RQ2] comparator with fixed 97 % reset ratio
    assign um_scaled  = {7'h0, um} * {16'h0, `NOPB_FULL_PCT};
    assign thr_scaled = {9'h0, threshold} * {16'h0, `NOPB_RESET_PCT};
    assign above       = um > {2'h0, threshold};
    assign below_reset = um_scaled < thr_scaled;
    assign next_pickup = !mode_off && (above || (pickup && !below_reset));

    // [RQ4] [RQ7] [RQ8] start only when not blocked, blocked otherwise
    assign next_start   = next_pickup && !(block_matrix_in | soft_block | mode_block);
    assign next_blocked = next_pickup &&  (block_matrix_in | soft_block | mode_block);

    // [RQ15] ratio in hundredths; threshold never below its minimum
    assign ratio_full = um_scaled / {9'h0, threshold};

    // faulted phases: those collapsed below half nominal
    assign fault_type = {phase3_voltage < `NOPB_PHASE_LOW,
                         phase2_voltage < `NOPB_PHASE_LOW,
                         phase1_voltage < `NOPB_PHASE_LOW};

    // free running millisecond stamp; parameter shortens it in simulation
    always @(posedge clk) begin
        if (reset) begin
            tick_count <= 32'h0;
            ms_count   <= 32'h0;
        end else if (tick_count == STAMP_CYCLES - 1) begin
            tick_count <= 32'h0;
            ms_count   <= ms_count + 32'h1;
        end else begin
            tick_count <= tick_count + 32'h1;
        end
    end

    // [RQ22] all decisions taken only on the processing cycle pulse
    always @(posedge clk) begin
        if (reset) begin
            pickup        <= 1'b0;
            start         <= 1'b0;
            blocked       <= 1'b0;
            trip          <= 1'b0;
            block_sampled <= 1'b0;
            source        <= `NOPB_SRC_NONE;
            ratio         <= 16'h0;
            release_start <= 1'b0;
            block_event   <= 1'b0;
            display_event <= 1'b0;
        end else if (cycle_start) begin
            // [RQ5] [RQ6] blocking sampled once per cycle
            block_sampled <= block_matrix_in | soft_block | mode_block;
            pickup        <= next_pickup;
            start         <= next_start;
            blocked       <= next_blocked;
            // [RQ20] instant mode trips with start
            trip          <= next_start && instant;
            source        <= next_source;
            // [RQ16] saturating ratio
            if (ratio_full > {7'h0, `NOPB_RATIO_MAX})
                ratio <= `NOPB_RATIO_MAX;
            else
                ratio <= ratio_full[15:0];
            // [RQ9] start dropping for any cause starts release handling
            release_start <= start && !next_start;
            // [RQ10] notify on the rising edge of blocked
            block_event   <= next_blocked && !blocked;
            display_event <= next_blocked && !blocked;
        end else begin
            // event strobes last one clock
            release_start <= 1'b0;
            block_event   <= 1'b0;
            display_event <= 1'b0;
        end
    end

    // [RQ10] [RQ20] stamp and process data captured at events
    always @(posedge clk) begin
        if (reset) begin
            event_stamp      <= 32'h0;
            event_voltage    <= 16'h0;
            event_fault_type <= 3'h0;
            block_count      <= 16'h0;
        end else if (cycle_start) begin
            if ((next_start && !start) || (next_blocked && !blocked)
                    || (start && !next_start)) begin
                event_stamp <= ms_count;
            end
            if (next_blocked && !blocked) begin
                event_voltage    <= um;
                event_fault_type <= fault_type;
                block_count      <= block_count + 16'h1;
            end
        end
    end

    // [RQ17] [RQ18] timer figures follow the adjacent timer block
    always @(posedge clk) begin
        if (reset) begin
            remaining <= 16'h0;
            expected  <= 16'h0;
            counting  <= 1'b0;
        end else begin
            counting  <= timer_counting && start;
            expected  <= timer_expected;
            remaining <= (timer_counting && start) ? timer_remaining : 16'h0;
        end
    end

    // read multiplexer; unmapped offsets read zero
    always @* begin
        case (address)
            `NOPB_REG_THRESH:  next_readdata = {18'h0, threshold};
            `NOPB_REG_CONFIG:  next_readdata = {24'h0, config_reg};
            `NOPB_REG_STATUS:  next_readdata = {21'h0, counting, source, mode,
                                                block_sampled, trip, blocked,
                                                start, pickup};
            `NOPB_REG_RATIO:   next_readdata = {16'h0, ratio};
            `NOPB_REG_TIMES:   next_readdata = {expected, remaining};
            `NOPB_REG_BLKINFO: next_readdata = {13'h0, event_fault_type, event_voltage};
            `NOPB_REG_STAMP:   next_readdata = event_stamp;
            `NOPB_REG_COUNT:   next_readdata = {16'h0, block_count};
            default:           next_readdata = 32'h0;
        endcase
    end

    // avalon slave: one wait cycle, then waitrequest low for one clock
    always @(posedge clk) begin
        if (reset) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
            readdata    <= read ? next_readdata : 32'h0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // [RQ3] writes land at the edge that ends the request
    always @(posedge clk) begin
        if (reset) begin
            threshold  <= `NOPB_THR_DEFAULT;
            config_reg <= `NOPB_CFG_DEFAULT;
        end else if (write && !waitrequest) begin
            if (address == `NOPB_REG_THRESH)
                threshold <= nopb_clamp_thr(writedata);
            if (address == `NOPB_REG_CONFIG)
                config_reg <= writedata[7:0];
        end
    end

endmodule // nopb_pickup

`default_nettype wire

// ---- verification/nopb_monitor.sv ----
// port checker for the neutral overvoltage pickup block
`timescale 1ns/100ps
`default_nettype none
module nopb_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire logic cycle_start,
    input wire logic pickup,
    input wire logic start,
    input wire logic blocked,
    input wire logic trip,
    input wire logic release_start,
    input wire logic block_event,
    input wire logic display_event
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_start_needs_pickup: assert property (start |-> pickup)
        else $error("start without pickup");
    a_no_start_blocked: assert property (!(start && blocked))
        else $error("start and blocked together");
    a_blocked_needs_pickup: assert property (blocked |-> pickup)
        else $error("blocked without pickup");
    a_trip_with_start: assert property (trip |-> start)
        else $error("trip without start");
    // levels may only move in the cycle after a processing-cycle edge
    a_cycle_boundary: assert property (!$past(cycle_start) |-> $stable({pickup, start, blocked, trip}))
        else $error("status moved off a cycle boundary");
    a_start_release: assert property ($fell(start) |-> ##[0:1] release_start)
        else $error("start fell without release");
    a_release_pulse: assert property (release_start |=> !release_start)
        else $error("release longer than one cycle");
    a_block_events: assert property ($rose(blocked) |-> ##[0:1] (block_event && display_event))
        else $error("blocked rose without events");
    a_event_pulse: assert property (block_event |=> !block_event)
        else $error("block event longer than one cycle");
    a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus access not answered");

    c_start: cover property ($rose(start));
    c_blocked: cover property ($rose(blocked));
    c_trip: cover property ($rose(trip));
endmodule // nopb_monitor

bind nopb_pickup nopb_monitor u_mon (
    .clk(clk), .reset(reset), .read(read), .write(write), .waitrequest(waitrequest),
    .cycle_start(cycle_start), .pickup(pickup), .start(start), .blocked(blocked),
    .trip(trip), .release_start(release_start), .block_event(block_event),
    .display_event(display_event)
);
`default_nettype wire

// ---- verification/nopb_cpu_model.sv ----
// behavioural protection cpu feeding measurements and blocking
`timescale 1ns/100ps
`default_nettype none
module nopb_cpu_model #(
    parameter PERIOD = 8
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [15:0] um,
    input  wire logic        blk,
    output logic             cycle_start,
    output logic [15:0]      phase_v,
    output logic             block_out
);
    int cnt;

    // cycle pulse every PERIOD clocks; values move mid-cycle only
    always @(posedge clk) begin
        if (reset) begin
            cnt <= 0;
            cycle_start <= 1'b0;
            phase_v <= 16'h0000;
            block_out <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            cycle_start <= (cnt == PERIOD - 1);
            if (cnt == PERIOD / 2) begin
                phase_v <= um;
                block_out <= blk;
            end
        end
    end
endmodule // nopb_cpu_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the neutral overvoltage pickup block
`timescale 1ns/100ps
`default_nettype none
`include "nopb_defs.vh"
module tb_top;
    logic        clk, reset, read, write, waitrequest, cycle_start;
    logic        pn, r3, r4, blk, bmi, tcnt, pickup, start, blocked, trip;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, rdat;
    logic [15:0] um, pv, trem, texp;
    logic [15:0] tbl [4] = '{16'd1001, 16'd970, 16'd969, 16'd1000};
    int          err_count, checks, seed, tick, ep, thr, i;

    nopb_pickup #(.STAMP_CYCLES(10)) dut (
        .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .cycle_start(cycle_start), .phase1_voltage(pv), .phase2_voltage(pv),
        .phase3_voltage(pv), .third_voltage_channel(pv), .fourth_voltage_channel(pv),
        .phase_neutral_present(pn), .third_is_residual(r3), .fourth_is_residual(r4),
        .block_matrix_in(bmi), .timer_counting(tcnt), .timer_remaining(trem),
        .timer_expected(texp), .pickup(pickup), .start(start), .blocked(blocked),
        .trip(trip), .release_start(), .block_event(), .display_event(),
        .event_stamp(), .event_voltage(), .event_fault_type()
    );
    nopb_cpu_model #(.PERIOD(8)) cpu (
        .clk(clk), .reset(reset), .um(um), .blk(blk), .cycle_start(cycle_start),
        .phase_v(pv), .block_out(bmi)
    );

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        tick++;
        if (tick == 20000) begin
            err_count++;
            finish_test;
        end
    end

    task finish_test;
        if (err_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one avalon access; held until waitrequest is seen low
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rdat = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    // two processing cycles so the model's new values get sampled
    task settle;
        repeat (2) begin
            @(posedge clk);
            while (cycle_start !== 1'b1) @(posedge clk);
        end
        @(posedge clk);
    endtask

    task apply(input logic [15:0] u, input logic b);
        um <= u;
        blk <= b;
        settle;
    endtask

    // reference hysteresis: set above, clear below 97 percent
    task pu(input logic [15:0] u);
        apply(u, 1'b0);
        if (u > thr) ep = 1;
        else if (u * 100 < thr * 97) ep = 0;
        chk(pickup, ep);
        chk(start, ep);
    endtask

    initial begin
        {read, write, reset, blk, um, address, writedata} = '0;
        reset = 1'b1;
        {pn, r3, r4, tcnt} = 4'hf;
        seed = 85;
        thr = 1000;
        trem = $random(seed);
        texp = $random(seed);
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        bus(0, `NOPB_REG_THRESH, 0);
        chk(rdat, `NOPB_THR_DEFAULT);
        bus(0, `NOPB_REG_CONFIG, 0);
        chk(rdat, `NOPB_CFG_DEFAULT);
        bus(0, 5'h02, 0);
        chk(rdat, 0);
        bus(1, `NOPB_REG_THRESH, 32'h3fff);
        bus(0, `NOPB_REG_THRESH, 0);
        chk(rdat, `NOPB_THR_MAX);
        bus(1, `NOPB_REG_THRESH, 0);
        bus(0, `NOPB_REG_THRESH, 0);
        chk(rdat, `NOPB_THR_MIN);
        bus(1, `NOPB_REG_THRESH, thr);
        for (i = 0; i < 4; i++) pu(tbl[i]);
        for (i = 0; i < 30; i++) pu(940 + ($random(seed) & 127));
        pu(1500);
        bus(1, `NOPB_REG_RATIO, 32'hffff);
        bus(0, `NOPB_REG_RATIO, 0);
        chk(rdat, 150);
        bus(0, `NOPB_REG_TIMES, 0);
        chk(rdat, {texp, trem});
        apply(1500, 1'b1);
        chk({start, blocked}, 2'b01);
        bus(0, `NOPB_REG_COUNT, 0);
        chk(rdat, 1);
        bus(0, `NOPB_REG_BLKINFO, 0);
        chk(rdat, 32'h000705dc);
        apply(0, 1'b1);
        apply(1500, 1'b1);
        chk({start, blocked}, 2'b01);
        apply(1500, 1'b0);
        chk(start, 1);
        bus(1, `NOPB_REG_CONFIG, 8'h19);
        settle;
        chk({start, blocked}, 2'b01);
        bus(1, `NOPB_REG_CONFIG, 8'h11);
        settle;
        chk({start, blocked}, 2'b10);
        bus(1, `NOPB_REG_CONFIG, 8'h81);
        settle;
        chk({start, trip}, 2'b11);
        for (i = 1; i < 6; i++) begin
            bus(1, `NOPB_REG_CONFIG, i);
            settle;
            bus(0, `NOPB_REG_STATUS, 0);
            chk(rdat[7:5], i);
        end
        chk(pickup, 0);
        for (i = 1; i < 4; i++) begin
            bus(1, `NOPB_REG_CONFIG, 1 + (i << 5));
            settle;
            bus(0, `NOPB_REG_STATUS, 0);
            chk(rdat[9:8], i);
        end
        bus(1, `NOPB_REG_CONFIG, 1);
        settle;
        bus(0, `NOPB_REG_STATUS, 0);
        chk(rdat[9:8], `NOPB_SRC_CALC);
        {pn, r3, r4} <= 3'h0;
        settle;
        bus(0, `NOPB_REG_STATUS, 0);
        chk(rdat[9:8], `NOPB_SRC_NONE);
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
